/* File: verilog/reset_state_and_clock_tree.sv */
// Purpose: reset state loading and clock chain control
// Assumes: one 100 MHz clock, ahb-lite slave, zero wait states
// Notes:   pll and oscillators are analog; this models their control
//
// How it works
// - any reset loads program counter 0xfff0
// - interrupt vector resets to 0, single
// - vector written by bus or reti update
// - pc bytes reset to 0xff, 0xf0
// - return address bytes reset to 0xff
// - status top ones, cause bits, low zeros
// - speed reg 0x93, extended config 0x01
// - retained data kept on pin, watchdog
// - port registers zero, direction 0xff
// - other registers clear to zero, clock enables set to 0x3
// - oscillator times pll gives core base
// - realtime oscillator runs timer when main off
// - multiplier factor fixed at fifty
// - prescaler divides by one to eight
// - postscaler divides by one to four
// - core divider leaves system clock undivided
// - joint re-enable waits oscillator time only
// - fuse settings static, not bus reachable
// - prescale divisor is field plus one
// - postscale divisor is field plus one
// - pll wait 128 us to 8.256 ms
// - osc wait 320 us to 1048.64 ms
//
// Decided for this implementation: the register addresses and the AHB-Lite interface to the registers.
`include "rst_clk_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module reset_state_and_clock_tree #(
    parameter int unsigned PLL_CYC [8] = '{
        `PLL_US0*`CLK_MHZ, `PLL_US1*`CLK_MHZ, `PLL_US2*`CLK_MHZ,
        `PLL_US3*`CLK_MHZ, `PLL_US4*`CLK_MHZ, `PLL_US5*`CLK_MHZ,
        `PLL_US6*`CLK_MHZ, `PLL_US7*`CLK_MHZ},
    parameter int unsigned OSC_CYC [8] = '{
        `OSC_US0*`CLK_MHZ, `OSC_US1*`CLK_MHZ, `OSC_US2*`CLK_MHZ,
        `OSC_US3*`CLK_MHZ, `OSC_US4*`CLK_MHZ, `OSC_US5*`CLK_MHZ,
        `OSC_US6*`CLK_MHZ, `OSC_US7*`CLK_MHZ}
) (
    // clock and power-on reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // reset sources, asynchronous pins
    input  wire logic        ext_rst_n,
    input  wire logic        brownout,
    input  wire logic        wdt_overflow,
    // static fuse word
    input  wire logic [15:0] clock_fuse_word,
    // cpu side
    input  wire logic        reti_update,
    input  wire logic [15:0] cur_pc,
    output logic             cpu_reset,
    output logic [15:0]      pc_reset_addr,
    output logic [15:0]      irq_vector,
    output logic             core_tick,
    // clock chain
    input  wire logic        rt_osc_input,
    output logic             main_osc_drive_en,
    output logic             rt_osc_drive_en,
    output logic             pll_run,
    output logic             clock_ready,
    output logic [3:0]       prescale_div,
    output logic [5:0]       pll_mult,
    output logic [2:0]       postscale_div,
    // port pins
    output logic [7:0]       port_direction_reg,
    output logic [7:0]       port_data
);
    // wait table lookup, used for both start-up fields
    // 27 bits: the longest oscillator wait at 100 MHz needs them all
    function automatic logic [26:0] wait_of(input int unsigned t [8],
                                            input logic [2:0] sel);
        wait_of = t[sel][26:0];
    endfunction

    // pin synchronisers: ext reset low, brownout, watchdog, rt clock
    logic [3:0]  s1_q, s2_q, s3_q, pin_q;
    wire  [3:0]  pin_raw = {rt_osc_input, wdt_overflow, brownout, ~ext_rst_n};
    wire  [3:0]  pin_stable = ~(s2_q ^ s3_q);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1_q  <= 4'h0;
            s2_q  <= 4'h0;
            s3_q  <= 4'h0;
            pin_q <= 4'h0;
        end else begin
            s1_q  <= pin_raw;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            pin_q <= (pin_stable & s3_q) | (~pin_stable & pin_q);
        end
    end
    wire rst_pin = pin_q[0];
    wire rst_bo  = pin_q[1];
    wire rst_wdt = pin_q[2];
    wire rt_lvl  = pin_q[3];

    // fuses caught once after power-on release
    logic        fuse_ld_q;
    logic [15:0] fuse_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fuse_ld_q <= 1'b0;
            fuse_q    <= 16'h0000;
        end else if (!fuse_ld_q) begin
            fuse_ld_q <= 1'b1;
            fuse_q    <= clock_fuse_word;
        end
    end
    wire [2:0] pll_prescale_sel  = fuse_q[`F_PIN_HI -: 3];
    wire [1:0] pll_postscale_sel = fuse_q[`F_POUT_HI -: 2];
    wire [2:0] pll_startup_sel   = fuse_q[`F_WUDP_HI -: 3];
    wire [2:0] osc_startup_sel   = fuse_q[`F_WUDX_HI -: 3];

    // reset sequencer: hold while a source stands, then wait start-up
    rst_clk_pkg::rst_state_t st_q, st_d;
    logic [26:0] rcnt_q;
    rst_clk_pkg::cause_t     cause_q;
    logic        warm_q;
    wire any_src = rst_pin | rst_bo | rst_wdt;
    wire [26:0] osc_cyc = wait_of(OSC_CYC, osc_startup_sel);
    // hold lasts until the fuses are caught, so the wait never
    // uses the cleared fuse copy of the first cycle
    always_comb begin
        case (st_q)
            rst_clk_pkg::ST_RUN:  st_d = any_src ? rst_clk_pkg::ST_HOLD : st_q;
            rst_clk_pkg::ST_HOLD: st_d = (any_src || !fuse_ld_q) ? st_q : rst_clk_pkg::ST_WAIT;
            rst_clk_pkg::ST_WAIT: st_d = any_src ? rst_clk_pkg::ST_HOLD :
                                  (rcnt_q == 27'h0 ? rst_clk_pkg::ST_RUN : st_q);
            default:              st_d = rst_clk_pkg::ST_HOLD;
        endcase
    end
    // count reloads outside wait, so wait always starts from full
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q    <= rst_clk_pkg::ST_HOLD;
            rcnt_q  <= 27'h0;
            cause_q <= rst_clk_pkg::CAUSE_PIN;
            warm_q  <= 1'b0;
        end else begin
            st_q   <= st_d;
            rcnt_q <= (st_q != rst_clk_pkg::ST_WAIT) ? osc_cyc :
                      rcnt_q - 27'h1;
            // cause latched while held; brown-out outranks watchdog
            if (any_src) begin
                cause_q <= rst_bo  ? rst_clk_pkg::CAUSE_BO :
                           rst_wdt ? rst_clk_pkg::CAUSE_WDT :
                                     rst_clk_pkg::CAUSE_PIN;
                warm_q  <= ~rst_bo;
            end
        end
    end
    wire in_rst = (st_q != rst_clk_pkg::ST_RUN);

    // bus address phase capture
    wire        take = hsel & hready & htrans[1];
    logic       wr_q;
    logic [7:0] wa_q;
    wire  [7:0] a = haddr[7:0];

    // software registers
    logic [15:0] pc_q, ret_q, vec_q;
    logic [7:0]  stat_lo_q, speed_q, extended_config_reg_q, dir_q, port_q;
    logic [31:0] keep_q;
    logic [1:0]  clk_en_q;
    logic [23:0] rtcnt_q;
    wire  wr_ok = wr_q & ~in_rst;
    wire  w_pc  = wr_ok & (wa_q == `A_PC);
    wire  w_ret = wr_ok & (wa_q == `A_RET);
    wire  w_st  = wr_ok & (wa_q == `A_STATUS);
    wire  w_sp  = wr_ok & (wa_q == `A_SPEED);
    wire  w_xc  = wr_ok & (wa_q == `A_EXTENDED_CONFIG_REG);
    wire  w_vec = wr_ok & (wa_q == `A_VEC);
    wire  w_dir = wr_ok & (wa_q == `A_DIR);
    wire  w_prt = wr_ok & (wa_q == `A_PORT);
    wire  w_kp  = wr_ok & (wa_q == `A_KEEP);
    wire  w_ck  = wr_ok & (wa_q == `A_CLKCTL);

    // register updates; internal reset loads documented values
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pc_q      <= `PC_RST;
            ret_q     <= `RET_RST;
            vec_q     <= `VEC_RST;
            stat_lo_q <= 8'h00;
            speed_q   <= `SPEED_RST;
            extended_config_reg_q    <= `EXTENDED_CONFIG_REG_RST;
            dir_q     <= `DIR_RST;
            port_q    <= 8'h00;
            clk_en_q  <= 2'h3;
        end else if (in_rst) begin
            pc_q      <= `PC_RST;
            ret_q     <= `RET_RST;
            vec_q     <= `VEC_RST;
            stat_lo_q <= 8'h00;
            speed_q   <= `SPEED_RST;
            extended_config_reg_q    <= `EXTENDED_CONFIG_REG_RST;
            dir_q     <= `DIR_RST;
            port_q    <= 8'h00;
            clk_en_q  <= 2'h3;
        end else begin
            if (w_pc)  pc_q <= hwdata[15:0];
            if (w_ret) ret_q <= hwdata[15:0];
            if (reti_update) vec_q <= cur_pc;
            else if (w_vec) vec_q <= hwdata[15:0];
            if (w_st)  stat_lo_q <= {5'h00, hwdata[2:0]};
            if (w_sp)  speed_q <= hwdata[7:0];
            if (w_xc)  extended_config_reg_q <= hwdata[7:0];
            if (w_dir) dir_q <= hwdata[7:0];
            if (w_prt) port_q <= hwdata[7:0];
            if (w_ck)  clk_en_q <= hwdata[1:0];
        end
    end

    // retained data: cleared on cold resets, kept on warm ones
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            keep_q <= 32'h0;
        else if (in_rst && !warm_q)
            keep_q <= 32'h0;
        else if (w_kp)
            keep_q <= hwdata;
    end

    // clock wake: joint re-enable uses oscillator time only
    // counter as wide as the oscillator wait table
    logic [1:0]  ck_prev_q;
    logic [26:0] wk_q;
    logic        rdy_q;
    wire  osc_on = clk_en_q[0];
    wire  pll_on = clk_en_q[1];
    wire  osc_up = osc_on & ~ck_prev_q[0];
    wire  pll_up = pll_on & ~ck_prev_q[1];
    wire [26:0] wk_load = osc_up ? osc_cyc :
                          wait_of(PLL_CYC, pll_startup_sel);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ck_prev_q <= 2'h3;
            wk_q      <= 27'h0;
            rdy_q     <= 1'b0;
        end else begin
            ck_prev_q <= clk_en_q;
            if (!osc_on || !pll_on) begin
                wk_q  <= 27'h0;
                rdy_q <= 1'b0;
            end else if (osc_up || pll_up) begin
                wk_q  <= wk_load;
                rdy_q <= 1'b0;
            end else if (wk_q != 27'h0) begin
                wk_q  <= wk_q - 27'h1;
            end else begin
                rdy_q <= ~in_rst;
            end
        end
    end

    // realtime timer counts rt oscillator edges, independent of main
    logic rt_prev_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rt_prev_q <= 1'b0;
            rtcnt_q   <= 24'h0;
        end else begin
            rt_prev_q <= rt_lvl;
            if (in_rst)
                rtcnt_q <= 24'h0;
            else if (rt_lvl && !rt_prev_q)
                rtcnt_q <= rtcnt_q + 24'h1;
        end
    end

    // core divider: only the core tick is slowed, system runs on
    logic [3:0] cdiv_q;
    logic       tick_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cdiv_q <= 4'h0;
            tick_q <= 1'b0;
        end else if (in_rst || cdiv_q == speed_q[3:0]) begin
            cdiv_q <= 4'h0;
            tick_q <= ~in_rst & rdy_q;
        end else begin
            cdiv_q <= cdiv_q + 4'h1;
            tick_q <= 1'b0;
        end
    end

    // read mux for the address phase
    logic [31:0] rmux;
    wire  [7:0]  status = {`STAT_TOP, cause_q, stat_lo_q[2:0]};
    always_comb begin
        case (a)
            `A_PC:     rmux = {16'h0, pc_q};
            `A_RET:    rmux = {16'h0, ret_q};
            `A_STATUS: rmux = {24'h0, status};
            `A_SPEED:  rmux = {24'h0, speed_q};
            `A_EXTENDED_CONFIG_REG:   rmux = {24'h0, extended_config_reg_q};
            `A_VEC:    rmux = {16'h0, vec_q};
            `A_DIR:    rmux = {24'h0, dir_q};
            `A_PORT:   rmux = {24'h0, port_q};
            `A_KEEP:   rmux = keep_q;
            `A_CLKCTL: rmux = {29'h0, rdy_q, clk_en_q};
            `A_RTCNT:  rmux = {8'h0, rtcnt_q};
            default:   rmux = 32'h0;
        endcase
    end

    // bus slave: zero wait, always okay
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q      <= 1'b0;
            wa_q      <= 8'h00;
            hrdata    <= 32'h0;
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end else begin
            wr_q      <= take & hwrite;
            wa_q      <= a;
            hrdata    <= (take && !hwrite) ? rmux : 32'h0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // outputs, all registered
    // reset values are shown in the same cycle as cpu_reset rises;
    // taking the registers alone would show old values one cycle late
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cpu_reset          <= 1'b1;
            pc_reset_addr      <= `PC_RST;
            irq_vector         <= `VEC_RST;
            core_tick          <= 1'b0;
            main_osc_drive_en  <= 1'b0;
            rt_osc_drive_en    <= 1'b0;
            pll_run            <= 1'b0;
            clock_ready        <= 1'b0;
            prescale_div       <= 4'h1;
            pll_mult           <= `PLL_MULT;
            postscale_div      <= 3'h1;
            port_direction_reg <= `DIR_RST;
            port_data          <= 8'h00;
        end else begin
            cpu_reset          <= in_rst;
            pc_reset_addr      <= in_rst ? `PC_RST : pc_q;
            irq_vector         <= in_rst ? `VEC_RST : vec_q;
            core_tick          <= tick_q;
            main_osc_drive_en  <= osc_on & ~fuse_q[`F_XDIS];
            rt_osc_drive_en    <= ~fuse_q[`F_RTDIS];
            pll_run            <= pll_on & osc_on;
            clock_ready        <= rdy_q;
            prescale_div       <= {1'b0, pll_prescale_sel} + 4'h1;
            pll_mult           <= `PLL_MULT;
            postscale_div      <= {1'b0, pll_postscale_sel} + 3'h1;
            port_direction_reg <= in_rst ? `DIR_RST : dir_q;
            port_data          <= in_rst ? 8'h00 : port_q;
        end
    end
endmodule
`default_nettype wire

/* File: shared/rst_clk_consts.svh */
// Purpose: offsets, fields, reset values and timing counts
// Assumes: 100 MHz hclk
// Notes:   startup waits are kept in microseconds
`ifndef RST_CLK_CONSTS_SVH
`define RST_CLK_CONSTS_SVH
`define CLK_MHZ      100
// register byte offsets
`define A_PC         8'h00
`define A_RET        8'h04
`define A_STATUS     8'h08
`define A_SPEED      8'h0c
`define A_EXTENDED_CONFIG_REG       8'h10
`define A_VEC        8'h14
`define A_DIR        8'h18
`define A_PORT       8'h1c
`define A_KEEP       8'h20
`define A_CLKCTL     8'h24
`define A_RTCNT      8'h28
// reset values
`define PC_RST       16'hfff0
`define RET_RST      16'hffff
`define STAT_TOP     3'h7
`define SPEED_RST    8'h93
`define EXTENDED_CONFIG_REG_RST     8'h01
`define DIR_RST      8'hff
`define VEC_RST      16'h0000
`define PLL_MULT     6'h32
// fuse field positions in the clock fuse word
`define F_XDIS       15
`define F_RTDIS      14
`define F_POUT_HI    13
`define F_PIN_HI     11
`define F_WUDP_HI    5
`define F_WUDX_HI    2
// pll start-up waits, microseconds
`define PLL_US0 128
`define PLL_US1 192
`define PLL_US2 320
`define PLL_US3 576
`define PLL_US4 1088
`define PLL_US5 2112
`define PLL_US6 4160
`define PLL_US7 8256
// oscillator start-up waits, microseconds
`define OSC_US0 320
`define OSC_US1 1088
`define OSC_US2 4160
`define OSC_US3 8256
`define OSC_US4 16448
`define OSC_US5 65600
`define OSC_US6 524352
`define OSC_US7 1048640
`endif

/* File: shared/rst_clk_pkg.sv */
// Purpose: types for the reset and clock block
// Assumes: nothing
// Notes:   states one bit apart along the path, except wait to run, which flips both
package rst_clk_pkg;
    typedef enum logic [1:0] {
        ST_RUN  = 2'h0,
        ST_HOLD = 2'h1,
        ST_WAIT = 2'h3
    } rst_state_t;
    typedef enum logic [1:0] {
        CAUSE_PIN = 2'h0,
        CAUSE_BO  = 2'h1,
        CAUSE_WDT = 2'h2
    } cause_t;
endpackage

/* File: tb/rst_clk_checker_assertions.sv */
// Purpose: port-level checks of reset values and clock chain
// Assumes: one clock, hresetn asynchronous active low
// Notes:   bound from the bench top
`timescale 1ns/1ns
`default_nettype none
module rst_clk_checker (
    // clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    // bus
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    // fuse and cpu side
    input wire logic [15:0] clock_fuse_word,
    input wire logic        cpu_reset,
    input wire logic [15:0] pc_reset_addr,
    input wire logic [15:0] irq_vector,
    input wire logic        core_tick,
    // clock chain and pins
    input wire logic        rt_osc_drive_en,
    input wire logic        clock_ready,
    input wire logic [3:0]  prescale_div,
    input wire logic [5:0]  pll_mult,
    input wire logic [2:0]  postscale_div,
    input wire logic [7:0]  port_direction_reg,
    input wire logic [7:0]  port_data
);
    // single domain, so clock and disable are declared once
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_pc_reset: assert property (cpu_reset |-> pc_reset_addr == 16'hfff0)
        else $error("pc not at reset address");
    a_vec_reset: assert property (cpu_reset |-> irq_vector == 16'h0000)
        else $error("vector not cleared in reset");
    a_port_reset: assert property (cpu_reset |-> port_direction_reg == 8'hff && port_data == 8'h00)
        else $error("port registers not at reset value");
    a_mult_fixed: assert property (!cpu_reset |-> pll_mult == 6'h32)
        else $error("multiplier not fifty");
    a_pre_div: assert property (!cpu_reset |-> prescale_div == {1'b0, clock_fuse_word[11:9]} + 4'h1)
        else $error("prescale divisor wrong");
    a_post_div: assert property (!cpu_reset |-> postscale_div == {1'b0, clock_fuse_word[13:12]} + 3'h1)
        else $error("postscale divisor wrong");
    a_rt_drive: assert property (!cpu_reset |-> rt_osc_drive_en == !clock_fuse_word[14])
        else $error("realtime drive enable wrong");
    a_tick_held: assert property (cpu_reset && $past(cpu_reset) |-> !core_tick)
        else $error("core tick during reset");
    a_rdata_idle: assert property ($past(!(hsel && hready && htrans[1] && !hwrite)) |-> hrdata == 32'h0)
        else $error("read data outside a read data phase");
    // main scenarios reached
    c_run: cover property ($fell(cpu_reset));
    c_ready: cover property ($rose(clock_ready));
    c_tick: cover property (core_tick);
    c_read: cover property (hrdata != 32'h0);
endmodule
`default_nettype wire

/* File: tb/reset_state_and_clock_tree_tb_top.sv */
// Purpose: self-checking bench for reset state and clock chain
// Assumes: zero-wait ahb-lite slave, shortened start-up counts
// Notes:   start-up tables are passed in as small cycle counts
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
    $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module reset_state_and_clock_tree_tb_top;
    // short start-up waits, in cycles
    localparam int unsigned PW [8] = '{40, 42, 44, 46, 48, 50, 52, 54};
    localparam int unsigned OW [8] = '{60, 64, 68, 72, 76, 80, 84, 88};
    localparam logic [15:0] FZ [3] = '{16'h7e00, 16'h9a1d, 16'h0000};
    // driven inputs
    logic hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, ext_rst_n = 1'b1;
    logic brownout = 1'b0, wdt_overflow = 1'b0, reti_update = 1'b0, rt_osc_input = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0;
    logic [15:0] clock_fuse_word = 16'h0, cur_pc = 16'h0;
    // observed outputs
    logic [31:0] hrdata;
    logic hreadyout, hresp, cpu_reset, core_tick, main_osc_drive_en, rt_osc_drive_en;
    logic pll_run, clock_ready;
    logic [15:0] pc_reset_addr, irq_vector;
    logic [3:0]  prescale_div;
    logic [5:0]  pll_mult;
    logic [2:0]  postscale_div;
    logic [7:0]  port_direction_reg, port_data;
    int          mismatches = 0, n_compared = 0, cyc = 0;

    reset_state_and_clock_tree #(.PLL_CYC(PW), .OSC_CYC(OW)) reset_state_and_clock_tree_inst (
        .hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .ext_rst_n, .brownout,
        .wdt_overflow, .clock_fuse_word, .reti_update, .cur_pc, .cpu_reset,
        .pc_reset_addr, .irq_vector, .core_tick, .rt_osc_input, .main_osc_drive_en,
        .rt_osc_drive_en, .pll_run, .clock_ready, .prescale_div, .pll_mult,
        .postscale_div, .port_direction_reg, .port_data);

    // 100 MHz clock and hang guard
    always #5 hclk = ~hclk;
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            wrap_up();
        end
    end

    // counts and verdict, then stop
    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // one single ahb-lite transfer, waits on hready in both phases
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge hclk);
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        bus(1'b0, a, 32'h0, d);
        `CHK(d, e)
        `CHK({hreadyout, hresp}, 2'b10)
    endtask

    // wait until the core is released from any reset
    task automatic to_run(output int n);
        n = 0;
        @(posedge hclk);
        while (cpu_reset !== 1'b0) begin
            @(posedge hclk);
            n++;
        end
    endtask

    // power-on with each fuse word: divisors, wait length, reset values
    task automatic t_por();
        logic [7:0]  ra [9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h40};
        logic [31:0] rv [9] = '{32'hfff0, 32'hffff, 32'he0, 32'h93, 32'h01, 32'h0, 32'hff,
                                32'h0, 32'h0};
        int n;
        foreach (FZ[i]) begin
            @(posedge hclk);
            hresetn <= 1'b0;
            clock_fuse_word <= FZ[i];
            repeat (3) @(posedge hclk);
            hresetn <= 1'b1;
            to_run(n);
            `CHK(n >= OW[FZ[i][2:0]] && n <= OW[FZ[i][2:0]] + 8, 1'b1)
            `CHK(prescale_div, {1'b0, FZ[i][11:9]} + 4'h1)
            `CHK(postscale_div, {1'b0, FZ[i][13:12]} + 3'h1)
            `CHK(pll_mult, 6'h32)
            `CHK(rt_osc_drive_en, ~FZ[i][14])
            foreach (ra[j]) rchk(ra[j], rv[j]);
        end
        $display("done: power-on");
    endtask

    // warm resets from pin and watchdog, cold reset from brown-out
    task automatic t_warm();
        logic [1:0] c;
        int n;
        for (c = 2'h0; c < 2'h3; c++) begin
            wr(8'h20, 32'hc0de5a5a);
            wr(8'h1c, 32'h3c);
            wr(8'h18, 32'h0f);
            wr(8'h14, 32'h1234);
            rchk(8'h14, 32'h1234);
            @(posedge hclk);
            ext_rst_n <= (c != 2'h0);
            brownout <= (c == 2'h1);
            wdt_overflow <= (c == 2'h2);
            repeat (8) @(posedge hclk);
            `CHK(cpu_reset, 1'b1)
            ext_rst_n <= 1'b1;
            brownout <= 1'b0;
            wdt_overflow <= 1'b0;
            to_run(n);
            rchk(8'h08, {24'h0, 3'h7, c, 3'h0});
            rchk(8'h20, (c == 2'h1) ? 32'h0 : 32'hc0de5a5a);
            rchk(8'h1c, 32'h0);
            rchk(8'h18, 32'hff);
            rchk(8'h14, 32'h0);
        end
        $display("done: warm resets");
    endtask

    // re-enable from clock stop and count the wait
    task automatic wake(input logic [31:0] v, input int e);
        int n;
        wr(8'h24, v);
        n = 0;
        while (clock_ready !== 1'b1) begin
            @(posedge hclk);
            n++;
        end
        `CHK(n + 2 >= e && n <= e + 4, 1'b1)
    endtask

    task automatic t_clock();
        logic [31:0] r0, r1;
        wr(8'h24, 32'h0);
        repeat (3) @(posedge hclk);
        `CHK(clock_ready, 1'b0)
        bus(1'b0, 8'h28, 32'h0, r0);
        repeat (5) begin
            rt_osc_input <= 1'b1;
            repeat (4) @(posedge hclk);
            rt_osc_input <= 1'b0;
            repeat (4) @(posedge hclk);
        end
        bus(1'b0, 8'h28, 32'h0, r1);
        `CHK(r1 - r0, 32'h5)
        wake(32'h3, OW[0]);
        `CHK(pll_run, 1'b1)
        `CHK(main_osc_drive_en, 1'b1)
        wr(8'h24, 32'h1);
        wake(32'h3, PW[0]);
        rchk(8'h24, 32'h7);
        $display("done: clock wake");
    endtask

    // vector update from a return with update option
    task automatic t_reti();
        @(posedge hclk);
        cur_pc <= 16'h4321;
        reti_update <= 1'b1;
        @(posedge hclk);
        reti_update <= 1'b0;
        repeat (3) @(posedge hclk);
        `CHK(irq_vector, 16'h4321)
        rchk(8'h14, 32'h4321);
        $display("done: vector update");
    endtask

    // core divider: ticks in a 40-cycle window per speed setting
    task automatic t_tick();
        logic [3:0] sp [4] = '{4'h0, 4'h3, 4'h4, 4'h7};
        int n;
        foreach (sp[i]) begin
            wr(8'h0c, {24'h0, 4'h9, sp[i]});
            repeat (16) @(posedge hclk);
            n = 0;
            repeat (40) begin
                @(posedge hclk);
                n += (core_tick === 1'b1);
            end
            `CHK(n, 40 / (sp[i] + 1))
            `CHK(clock_ready, 1'b1)
        end
        $display("done: core divider");
    endtask

    // main sequence
    initial begin
        repeat (8) @(posedge hclk);
        t_por();
        t_warm();
        t_clock();
        t_reti();
        t_tick();
        wrap_up();
    end
endmodule

bind reset_state_and_clock_tree rst_clk_checker rst_clk_checker_inst (
    .hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hrdata, .clock_fuse_word,
    .cpu_reset, .pc_reset_addr, .irq_vector, .core_tick, .rt_osc_drive_en, .clock_ready,
    .prescale_div, .pll_mult, .postscale_div, .port_direction_reg, .port_data);
`default_nettype wire
